// file: core/nvsc_host.sv
// host controller driving the parallel pins of a nonvolatile static ram
`timescale 1ns/1ps
`default_nettype none
module nvsc_host
    import nvsc_pkg::*;
#(
    parameter int WIDE = 1
)
(
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    // command port
    input  wire logic              i_req_valid,
    input  wire nvsc_req_t         i_req,
    output logic                   o_req_ready,
    output logic                   o_rsp_valid,
    output logic [DATA_W-1:0]      o_rsp_rdata,
    output logic                   o_rsp_refused,
    // memory pins
    output logic [ADDR_W-1:0]      o_mem_addr,
    output nvsc_ctl_t              o_mem_ctl,
    input  wire logic [DATA_W-1:0] i_mem_dq,
    output logic [DATA_W-1:0]      o_mem_dq,
    output logic                   o_mem_dq_oe,
    // busy pin, open drain
    input  wire logic              i_store_busy_n,
    output logic                   o_store_busy_n,
    output logic                   o_store_busy_oe,
    // status
    output logic                   o_busy_seen
);
    typedef enum logic [2:0]
    {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b011,
        ST_HOLD   = 3'b010,
        ST_HWREQ  = 3'b110,
        ST_WAITHI = 3'b111
    } nvsc_state_t;

    nvsc_state_t        state_q, state_d;
    nvsc_req_t          req_q, req_d;
    logic [CNT_W-1:0]   cnt_q, cnt_d;
    logic [2:0]         step_q, step_d;
    logic [DATA_W-1:0]  rdata_q, rdata_d;
    logic               rsp_q, rsp_d, ref_q, ref_d;
    logic               pull_q, pull_d;
    logic               lost_q, lost_d;
    logic [15:0]        seq_addr;
    logic               is_seq, is_wr, is_hw;

    function automatic logic op_is_seq(input nvsc_op_t op);
        return (op == NVSC_OP_STORE) || (op == NVSC_OP_RECALL) ||
               (op == NVSC_OP_AS_OFF) || (op == NVSC_OP_AS_ON);
    endfunction

    nvsc_seq_rom u_rom
    (
        .i_op   (req_q.op),
        .i_step (step_q),
        .o_addr (seq_addr)
    );

    assign is_seq = op_is_seq(req_q.op);
    assign is_wr  = (req_q.op == NVSC_OP_WRITE);
    assign is_hw  = (req_q.op == NVSC_OP_HWSTORE);
    assign o_req_ready = (state_q == ST_IDLE) && i_store_busy_n; // [RULE12]

    always_comb
    begin
        state_d = state_q;
        req_d   = req_q;
        cnt_d   = cnt_q;
        step_d  = step_q;
        rdata_d = rdata_q;
        rsp_d   = 1'b0;
        ref_d   = 1'b0;
        pull_d  = pull_q;
        lost_d  = lost_q;
        case (state_q)
            ST_IDLE:
            begin
                step_d = 3'h0;
                if (i_req_valid && o_req_ready)
                begin
                    req_d  = i_req;
                    cnt_d  = CNT_W'(SETUP_CYC);
                    lost_d = 1'b0;
                    if (i_req.op == NVSC_OP_HWSTORE)
                    begin
                        pull_d  = 1'b1; // [RULE8]
                        state_d = ST_HWREQ;
                    end
                    else
                        state_d = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // busy low before the strobe opens: the device refuses the
                // write; a fall once the strobe is open lets it finish
                if (!i_store_busy_n && is_wr)
                    lost_d = 1'b1; // [RULE15]
                // address settles before the strobe opens [RULE5]
                if (cnt_q <= CNT_W'(1))
                begin
                    cnt_d   = CNT_W'(STROBE_CYC);
                    state_d = ST_STROBE;
                end
                else
                    cnt_d = cnt_q - CNT_W'(1);
            end
            ST_STROBE:
            begin
                if (cnt_q <= CNT_W'(1))
                begin
                    rdata_d = i_mem_dq; // [RULE1] [RULE3]
                    cnt_d   = CNT_W'(HOLD_CYC);
                    state_d = ST_HOLD;
                end
                else
                    cnt_d = cnt_q - CNT_W'(1);
            end
            ST_HOLD:
            begin
                if (cnt_q <= CNT_W'(1))
                begin
                    if (is_seq && step_q != 3'h5)
                    begin
                        // next read of the sequence, back to back [RULE22]
                        step_d  = step_q + 3'h1;
                        cnt_d   = CNT_W'(SETUP_CYC);
                        state_d = ST_SETUP;
                    end
                    else
                    begin
                        rsp_d   = 1'b1;
                        ref_d   = lost_q; // [RULE15]
                        state_d = (is_seq && req_q.op != NVSC_OP_AS_OFF &&
                                   req_q.op != NVSC_OP_AS_ON)
                                  ? ST_WAITHI : ST_IDLE;
                    end
                end
                else
                    cnt_d = cnt_q - CNT_W'(1);
            end
            ST_HWREQ:
            begin
                // hold the pin low for one setup time then let go [RULE13]
                if (cnt_q <= CNT_W'(1))
                begin
                    pull_d  = 1'b0;
                    rsp_d   = 1'b1;
                    state_d = ST_WAITHI;
                end
                else
                    cnt_d = cnt_q - CNT_W'(1);
            end
            ST_WAITHI:
            begin
                // device may take a while to pull busy low; wait for high
                // after release, no access until then [RULE14] [RULE17]
                if (i_store_busy_n && cnt_q == CNT_W'(0))
                    state_d = ST_IDLE;
                else if (cnt_q != CNT_W'(0))
                    cnt_d = cnt_q - CNT_W'(1);
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q <= ST_IDLE;
            req_q   <= '0;
            cnt_q   <= '0;
            step_q  <= 3'h0;
            rdata_q <= '0;
            rsp_q   <= 1'b0;
            ref_q   <= 1'b0;
            pull_q  <= 1'b0;
            lost_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            req_q   <= req_d;
            cnt_q   <= cnt_d;
            step_q  <= step_d;
            rdata_q <= rdata_d;
            rsp_q   <= rsp_d;
            ref_q   <= ref_d;
            pull_q  <= pull_d;
            lost_q  <= lost_d;
        end
    end

    // pin drive; write strobe idles high from reset onward [RULE18]
    always_comb
    begin
        logic active;
        active = (state_q == ST_SETUP) || (state_q == ST_STROBE) ||
                 (state_q == ST_HOLD);
        o_mem_addr = req_q.addr;
        if (is_seq)
            o_mem_addr = {1'b0, seq_addr}; // [RULE22]
        o_mem_ctl.ce_n = !(state_q == ST_STROBE);
        o_mem_ctl.we_n = !(state_q == ST_STROBE && is_wr); // [RULE4]
        o_mem_ctl.oe_n = !(state_q == ST_STROBE && !is_wr); // [RULE7]
        o_mem_ctl.ub_n = (WIDE != 0) ? !(active && (is_seq || req_q.be[1]))
                                     : 1'b1; // [RULE2] [RULE6]
        o_mem_ctl.lb_n = !(active && (is_seq || req_q.be[0]));
        o_mem_dq    = req_q.wdata;
        o_mem_dq_oe = active && is_wr && !is_hw; // [RULE7]
    end

    assign o_store_busy_n  = 1'b0;
    assign o_store_busy_oe = pull_q; // [RULE13]
    assign o_rsp_valid     = rsp_q;
    assign o_rsp_rdata     = rdata_q;
    assign o_rsp_refused   = ref_q;
    assign o_busy_seen     = !i_store_busy_n; // [RULE16] [RULE21]

    sequence s_seq_start;
        state_q == ST_IDLE && i_req_valid && o_req_ready &&
        op_is_seq(i_req.op);
    endsequence

    a_we_oe_excl: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !(!o_mem_ctl.we_n && !o_mem_ctl.oe_n)) // [RULE7]
        else $error("write strobe and output gate low together");
    a_dq_wr_only: assert property (@(posedge i_core_clk) disable iff (i_rst)
        o_mem_dq_oe |-> (o_mem_ctl.oe_n && is_wr)) // [RULE7]
        else $error("data driven outside a write");
    a_addr_stable: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!o_mem_ctl.we_n && $past(!o_mem_ctl.we_n)) |->
        $stable(o_mem_addr)) // [RULE5]
        else $error("address moved during write");
    a_seq_first: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_seq_start |=> ##(SETUP_CYC) (o_mem_addr[15:0] == SEQ_A0)) // [RULE22]
        else $error("sequence did not open at first address");
    a_no_access_busy: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        (state_q == ST_IDLE && !i_store_busy_n) |-> !o_req_ready) // [RULE12]
        else $error("request accepted while busy low");
    a_hw_pull: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_q == ST_HWREQ) |-> o_store_busy_oe) // [RULE13]
        else $error("busy pin not pulled during hardware request");
    a_we_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_q == ST_IDLE || state_q == ST_WAITHI) |->
        (o_mem_ctl.we_n && o_mem_ctl.ce_n)) // [RULE18]
        else $error("strobes active while idle");
    a_seq_no_write: assert property (@(posedge i_core_clk)
        disable iff (i_rst)
        is_seq |-> o_mem_ctl.we_n) // [RULE22]
        else $error("write inside a sequence");
endmodule
`default_nettype wire

// file: core/nvsc_pkg.sv
// package: constants and carrier types for the nv sram host controller
// Functional notes
// RULE1: read happens with chip select and output gate low, write strobe, busy high.
// RULE2: in 16-bit mode, byte enables choose which read lanes drive.
// RULE3: read data follows address changes while the read stays enabled.
// RULE4: write happens with chip select and strobe low, busy high; end captures.
// RULE5: host holds address stable through the whole write cycle.
// RULE6: in 16-bit mode, byte enables choose which lanes a write updates.
// RULE7: host keeps output gate high during writes; device disables drivers anyway.
// RULE8: saves start by busy pin, address sequence, or power loss.
// RULE9: on power fail the device saves from its backup capacitor if enabled.
// RULE10: power-loss or pin saves are skipped without a write since last save.
// RULE11: sequence-started saves always execute.
// RULE12: no sram access while a save or restore runs.
// RULE13: busy pulled low starts a save after store_request_delay if latch set.
// RULE14: device holds busy low during any save, releasing at completion.
// RULE15: writes in progress get store_request_delay; new writes refused while busy low.
// RULE16: busy pulled low with latch clear still blocks access until released.
// RULE17: after a save, access waits until busy is seen high.
// RULE18: host keeps write strobe inactive after power-on restore until running.
// RULE19: without a backup capacitor the host issues the disable sequence.
// RULE20: device drives busy high briefly before releasing to pull-up.
// RULE21: device holds busy low during power-up restore.
// RULE22: save sequence is six reads 0x4E38 to 0x8FC0, aborted by other accesses.
// RULE23: device write latch set by writes, cleared by save or restore.
// RULE24: power fail is modelled as a digital input.
package nvsc_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 16;
    // sequence addresses, 16-bit low part of the address bus
    localparam logic [15:0] SEQ_A0         = 16'h4E38;
    localparam logic [15:0] SEQ_A1         = 16'hB1C7;
    localparam logic [15:0] SEQ_A2         = 16'h83E0;
    localparam logic [15:0] SEQ_A3         = 16'h7C1F;
    localparam logic [15:0] SEQ_A4         = 16'h703F;
    localparam logic [15:0] SEQ_STORE      = 16'h8FC0;
    localparam logic [15:0] SEQ_RECALL     = 16'h4C63;
    localparam logic [15:0] SEQ_AS_DISABLE = 16'h8B45;
    localparam logic [15:0] SEQ_AS_ENABLE  = 16'h4B46;
    // bus phase timing in ns and derived cycles at 125 MHz
    localparam int CLK_PERIOD_NS  = 8;
    localparam int T_SETUP_NS     = 16;
    localparam int T_STROBE_NS    = 48;
    localparam int T_HOLD_NS      = 16;
    localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC   = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W      = 8;

    typedef enum logic [2:0]
    {
        NVSC_OP_READ    = 3'h0,
        NVSC_OP_WRITE   = 3'h1,
        NVSC_OP_STORE   = 3'h2,
        NVSC_OP_RECALL  = 3'h3,
        NVSC_OP_AS_OFF  = 3'h4,
        NVSC_OP_AS_ON   = 3'h5,
        NVSC_OP_HWSTORE = 3'h6
    } nvsc_op_t;

    typedef struct packed
    {
        nvsc_op_t            op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [1:0]          be;
    } nvsc_req_t;

    typedef struct packed
    {
        logic                ce_n;
        logic                we_n;
        logic                oe_n;
        logic                ub_n;
        logic                lb_n;
    } nvsc_ctl_t;
endpackage

// file: core/nvsc_seq_rom.sv
// sequence address lookup for the six-read software commands
`timescale 1ns/1ps
`default_nettype none
module nvsc_seq_rom
    import nvsc_pkg::*;
(
    // selection
    input  wire nvsc_op_t    i_op,
    input  wire logic [2:0]  i_step,
    // address
    output logic [15:0]      o_addr
);
    always_comb
    begin
        case (i_step)
            3'h0:    o_addr = SEQ_A0;
            3'h1:    o_addr = SEQ_A1;
            3'h2:    o_addr = SEQ_A2;
            3'h3:    o_addr = SEQ_A3;
            3'h4:    o_addr = SEQ_A4;
            default:
            begin
                case (i_op)
                    NVSC_OP_RECALL: o_addr = SEQ_RECALL;
                    NVSC_OP_AS_OFF: o_addr = SEQ_AS_DISABLE; // [RULE19]
                    NVSC_OP_AS_ON:  o_addr = SEQ_AS_ENABLE;
                    default:        o_addr = SEQ_STORE;
                endcase
            end
        endcase
    end
endmodule
`default_nettype wire

// file: dv/nvsc_dev_model.sv
// behavioural nv static ram that answers the host's parallel pins
`timescale 1ns/1ps
`default_nettype none
module nvsc_dev_model
    import nvsc_pkg::*;
#(
    parameter int T_DLY = 8,
    // not a whole number of clocks, so busy never rises on a clock edge when a save ends
    parameter int T_ST  = 402
)
(
    // memory pins
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire nvsc_ctl_t         i_ctl,
    input  wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0]      o_dq,
    // busy pin and supply
    input  wire logic              i_busy_n,
    output logic                   o_busy_oe,
    output logic                   o_busy_v,
    input  wire logic              i_pfail,
    // status
    output int                     o_stores,
    output logic                   o_auto
);
    logic [15:0] mem [int];
    logic [15:0] rd, cur, wa, wd, ra;
    logic [15:0] sq [5];
    logic [1:0]  wb;
    logic        latch, act;
    int          step;
    wire logic rd_en = !i_ctl.ce_n && !i_ctl.oe_n && i_ctl.we_n
        && i_busy_n && !act;
    wire logic wr_live = !i_ctl.ce_n && !i_ctl.we_n
        && i_busy_n && !act;

    // disabled lanes show the inverse so a wrong lane pick is seen
    always @*
        rd = mem.exists(i_addr[15:0]) ? mem[i_addr[15:0]] : 16'h0000;
    assign o_dq = rd_en ? rd ^ {{8{i_ctl.ub_n}}, {8{i_ctl.lb_n}}}
        : ~rd;

    always @*
        if (wr_live)
            {wa, wd, wb} = {i_addr[15:0], i_dq, i_ctl.ub_n, i_ctl.lb_n};
    always @*
        if (rd_en)
            ra = i_addr[15:0];

    task automatic run(input bit drv, input bit cnt);
        act = 1'b1;
        o_busy_v = 1'b0;
        o_busy_oe = drv;
        #(T_ST);
        o_stores += int'(cnt);
        latch = 1'b0;
        o_busy_v = 1'b1;
        #(16);
        o_busy_oe = 1'b0;
        act = 1'b0;
    endtask

    // the write commits when the strobe or the select ends
    always @(negedge wr_live)
    begin
        cur = mem.exists(wa) ? mem[wa] : 16'h0000;
        if (!wb[0]) cur[7:0] = wd[7:0];
        if (!wb[1]) cur[15:8] = wd[15:8];
        mem[wa] = cur;
        latch = 1'b1;
        step = 0;
    end

    always @(negedge rd_en)
        if (step < 5)
            step = (ra == sq[step]) ? step + 1 : int'(ra == SEQ_A0);
        else
        begin
            step = 0;
            if (ra == SEQ_AS_DISABLE) o_auto = 1'b0;
            if (ra == SEQ_AS_ENABLE) o_auto = 1'b1;
            if (ra == SEQ_STORE) run(1'b1, 1'b1);
            if (ra == SEQ_RECALL) run(1'b1, 1'b0);
        end

    always @(negedge i_busy_n)
        if (!o_busy_oe)
        begin
            act = 1'b1;
            #(T_DLY);
            if (latch) run(1'b1, 1'b1);
            else wait (i_busy_n);
            act = 1'b0;
        end

    always @(posedge i_pfail)
        if (o_auto && latch) run(1'b1, 1'b1);

    initial
    begin
        sq = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
        {latch, step, o_stores, o_auto} = {1'b0, 0, 0, 1'b1};
        {o_busy_oe, o_busy_v} = 2'b01;
        run(1'b1, 1'b0);
    end
endmodule
`default_nettype wire

// file: dv/nvsc_host_bench.sv
// self-checking bench for the nv sram host controller
`timescale 1ns/1ps
`default_nettype none
module nvsc_host_bench
    import nvsc_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, req_v = 1'b0, pfail = 1'b0;
    nvsc_req_t   req = '0;
    logic        rdy, rsp_v, busy_seen, dq_oe, h_oe, h_v, d_oe, d_v, auto;
    logic        pwe, rsp_r, rref, ext_pull = 1'b0;
    logic [15:0] rsp_d, h_dq, d_dq, rdat, pa;
    logic [16:0] addr;
    logic [31:0] lf = 32'h0000_92d8;
    logic [15:0] sh [16];
    logic [15:0] sa [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    nvsc_ctl_t   ctl;
    int          stores, cyc, miscompares, cmp_count;
    // open drain: any party pulling low wins, pull-up otherwise
    wire logic busy_n = !(h_oe && !h_v) && !(d_oe && !d_v) && !ext_pull;
    wire logic [15:0] dq = dq_oe ? h_dq : d_dq;

    nvsc_host #(.WIDE(1)) i_nvsc_host (.i_core_clk(clk), .i_rst(rst),
        .i_req_valid(req_v), .i_req(req), .o_req_ready(rdy),
        .o_rsp_valid(rsp_v), .o_rsp_rdata(rsp_d), .o_rsp_refused(rsp_r),
        .o_mem_addr(addr), .o_mem_ctl(ctl), .i_mem_dq(dq), .o_mem_dq(h_dq),
        .o_mem_dq_oe(dq_oe), .i_store_busy_n(busy_n),
        .o_store_busy_n(h_v), .o_store_busy_oe(h_oe),
        .o_busy_seen(busy_seen));
    nvsc_dev_model i_nvsc_dev_model (.i_addr(addr), .i_ctl(ctl),
        .i_dq(dq), .o_dq(d_dq), .i_busy_n(busy_n), .o_busy_oe(d_oe),
        .o_busy_v(d_v), .i_pfail(pfail), .o_stores(stores), .o_auto(auto));

    always #4 clk = ~clk;

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [15:0] lanes(input logic [15:0] o, n,
                                          input logic [1:0] be);
        return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
    endfunction

    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, s);
        cmp_count++;
        if (e !== s)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic idle();
        int n;
        n = 0;
        while (rdy !== 1'b1 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // called at a falling edge; the request stands until a rising edge
    // samples ready high
    task automatic op(input nvsc_op_t c, input logic [15:0] a, d,
                      input logic [1:0] b);
        int n;
        idle();
        req = '{c, {1'b0, a}, d, b};
        req_v = 1'b1;
        do
            @(posedge clk);
        while (rdy !== 1'b1);
        @(negedge clk);
        req_v = 1'b0;
        n = 0;
        while (rsp_v !== 1'b1 && n < 200)
        begin
            @(negedge clk);
            n++;
        end
        chk("rsp_valid", 1, rsp_v);
        rdat = rsp_d;
        rref = rsp_r;
    endtask

    task automatic wr(input logic [3:0] a, input logic [1:0] be);
        lf = nxt(lf);
        op(NVSC_OP_WRITE, {12'h000, a}, lf[31:16], be);
        chk("refused", 0, rref);
        sh[a] = lanes(sh[a], lf[31:16], be);
    endtask

    task automatic rd(input logic [3:0] a, input logic [1:0] be);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        op(NVSC_OP_READ, {12'h000, a}, 16'h0000, be);
        chk("rdata", sh[a] & m, rdat & m);
    endtask

    task automatic pulse();
        pfail = 1'b1;
        @(negedge clk);
        idle();
        pfail = 1'b0;
    endtask

    task automatic sv(input nvsc_op_t c, input int k);
        op(c, 16'h0000, 16'h0000, 2'b11);
        @(negedge clk);
        idle();
        chk("stores", k, stores);
    endtask

    always @(negedge clk)
        if (rst)
            chk("we_n", 1, ctl.we_n);
        else
        begin
            if (busy_seen === 1'b1) chk("ready", 0, rdy);
            if (ctl.we_n === 1'b0) chk("oe_n", 1, ctl.oe_n);
            if (ctl.we_n === 1'b0 && pwe === 1'b0) chk("addr", pa, addr);
            pwe = ctl.we_n;
            pa = addr[15:0];
        end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            finish_test();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        for (int i = 0; i < 16; i++)
            wr(4'(i), 2'b11);
        for (int i = 0; i < 40; i++)
        begin
            lf = nxt(lf);
            if (lf[8]) wr(lf[3:0], lf[5:4]);
            else rd(lf[3:0], lf[7:6]);
        end
        sv(NVSC_OP_STORE, 1);
        sv(NVSC_OP_STORE, 2);
        sv(NVSC_OP_HWSTORE, 2);
        wr(1, 2'b11);
        sv(NVSC_OP_HWSTORE, 3);
        for (int i = 0; i < 5; i++)
            op(NVSC_OP_READ, sa[i], 16'h0000, 2'b11);
        wr(2, 2'b01);
        sv(NVSC_OP_READ, 3);
        sv(NVSC_OP_AS_OFF, 3);
        chk("auto", 0, auto);
        pulse();
        chk("stores", 3, stores);
        sv(NVSC_OP_AS_ON, 3);
        chk("auto", 1, auto);
        pulse();
        chk("stores", 4, stores);
        wr(3, 2'b10);
        sv(NVSC_OP_RECALL, 4);
        sv(NVSC_OP_HWSTORE, 4);
        // busy pulled low from outside just after a write is taken
        idle();
        fork
            op(NVSC_OP_WRITE, 16'h0000, ~sh[0], 2'b11);
            begin
                @(negedge clk);
                ext_pull = 1'b1;
            end
        join
        ext_pull = 1'b0;
        chk("refused", 1, rref);
        for (int i = 0; i < 4; i++)
            rd(4'(i), 2'b11);
        finish_test();
    end
endmodule
`default_nettype wire
